// [hdl/pwm_timing_pkg.sv]
// Shared constants and types of the three-phase PWM timing unit
package pwm_timing_pkg;
    // ==========================================
    // Widths
    localparam int CNT_W = 16;
    localparam int DEAD_W = 10;
    localparam int SYNC_W = 8;
    localparam int MINP_W = 10;
    localparam int STEER_W = 9;
    localparam int N_PHASE = 3;
    // ==========================================
    // Register byte offsets on the bus
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_HALF_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_DEAD = 8'h0c;
    localparam logic [7:0] ADDR_MIN_PULSE = 8'h10;
    localparam logic [7:0] ADDR_SYNC_WIDTH = 8'h14;
    localparam logic [7:0] ADDR_DUTY_A = 8'h18;
    localparam logic [7:0] ADDR_DUTY_B = 8'h1c;
    localparam logic [7:0] ADDR_DUTY_C = 8'h20;
    localparam logic [7:0] ADDR_STEER = 8'h24;
    // ==========================================
    // Field positions
    localparam int MODE_DOUBLE_BIT = 6;
    localparam int STATUS_HALF_BIT = 3;
    // ==========================================
    // Reset values
    localparam logic [CNT_W-1:0] HALF_PERIOD_RESET = 16'h0000;
    localparam logic [DEAD_W-1:0] DEAD_RESET = 10'h000;
    localparam logic [MINP_W-1:0] MIN_PULSE_RESET = 10'h000;
    localparam logic [SYNC_W-1:0] SYNC_WIDTH_RESET = 8'h27;
    localparam logic [CNT_W-1:0] DUTY_RESET = 16'h0000;
    localparam logic [STEER_W-1:0] STEER_RESET = 9'h000;
    // ==========================================
    // Bus slave states
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b100
    } bus_state_e;
endpackage

// [hdl/pwm_phase_gen.sv]
// One complementary, dead-time adjusted, center-based output pair
`timescale 1ns/100ps
`default_nettype none
module pwm_phase_gen #(
    parameter int CNT_W = 16,
    parameter int DEAD_W = 10
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Shared timebase and latched settings
    input wire logic [CNT_W-1:0] cnt,
    input wire logic second_half,
    input wire logic [CNT_W-1:0] half_period,
    input wire logic [DEAD_W-1:0] dead,
    input wire logic [CNT_W-1:0] duty,
    // Active-low switch commands
    output logic high_n,
    output logic low_n
);
    logic signed [CNT_W+1:0] hi_raw;
    logic signed [CNT_W+1:0] lo_raw;
    logic signed [CNT_W+1:0] tm_s;
    logic [CNT_W-1:0] hi_on;
    logic [CNT_W-1:0] lo_on;

    if (DEAD_W > CNT_W || CNT_W < 2) begin : g_bad_width
        $error("pwm_phase_gen: DEAD_W must not exceed CNT_W");
    end

    // On-time per half period, clamped to 0..half period
    always_comb begin
        tm_s = $signed({2'b00, half_period});
        hi_raw = $signed({2'b00, duty}) - $signed({{(CNT_W + 2 - DEAD_W){1'b0}}, dead});
        lo_raw = tm_s - $signed({2'b00, duty})
            - $signed({{(CNT_W + 2 - DEAD_W){1'b0}}, dead});
        hi_on = (hi_raw < 0) ? '0 : (hi_raw > tm_s) ? half_period : hi_raw[CNT_W-1:0];
        lo_on = (lo_raw < 0) ? '0 : (lo_raw > tm_s) ? half_period : lo_raw[CNT_W-1:0];
    end

    // High side is on around the period centre, low side at the ends;
    // each edge sits dead cycles away from the duty instant.
    // A zero on-time is gated explicitly: with a zero half period the
    // threshold would otherwise be 0 and match at cnt 0
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_n <= 1'b1;
            low_n <= 1'b1;
        end else if (ce) begin
            if (second_half) begin
                high_n <= !(cnt < hi_on);
                low_n <= !((lo_on != '0) && (cnt >= half_period - lo_on));
            end else begin
                high_n <= !((hi_on != '0) && (cnt >= half_period - hi_on));
                low_n <= !(cnt < lo_on);
            end
        end
    end

    // A zero on-time keeps the signal off
    property p_hi_off;
        @(posedge clk) disable iff (!arst_n)
        (ce && hi_on == '0) |=> high_n;
    endproperty
    a_hi_off: assert property (p_hi_off) else $error("high side on with zero on-time");

    property p_on_clamped;
        @(posedge clk) disable iff (!arst_n)
        (hi_on <= half_period) && (lo_on <= half_period);
    endproperty
    a_on_clamped: assert property (p_on_clamped) else $error("on-time beyond half period");
endmodule
`default_nettype wire

// [hdl/pwm_timing_unit.sv]
// Three-phase PWM timing unit with its AHB-Lite register file
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module pwm_timing_unit
    import pwm_timing_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Gate commands, active low
    output logic phase_a_high_out,
    output logic phase_a_low_out,
    output logic phase_b_high_out,
    output logic phase_b_low_out,
    output logic phase_c_high_out,
    output logic phase_c_low_out,
    // Sync and latched settings for later stages
    output logic period_sync_pulse,
    output logic sync_irq,
    output logic [STEER_W-1:0] steer_enable_out,
    output logic [MINP_W-1:0] min_pulse_active
);
    // ==========================================
    // Declarations
    bus_state_e state;
    logic [7:0] addr_q;
    logic addr_ok_q;
    logic accept;
    logic [31:0] rd_mux;
    logic mode_double;
    logic [CNT_W-1:0] half_period_count;
    logic [DEAD_W-1:0] dead_time_count;
    logic [MINP_W-1:0] min_pulse_count;
    logic [SYNC_W-1:0] sync_width_count;
    logic [CNT_W-1:0] duty_reg [N_PHASE];
    logic [STEER_W-1:0] output_steer_enable;
    logic [CNT_W-1:0] tm_lat;
    logic [DEAD_W-1:0] dead_lat;
    logic [SYNC_W-1:0] sync_w_lat;
    logic [CNT_W-1:0] duty_lat [N_PHASE];
    logic dbl_lat;
    logic [CNT_W-1:0] cnt;
    logic half;
    logic at_end;
    logic do_latch;
    logic [SYNC_W-1:0] sync_rem;
    logic [N_PHASE-1:0] high_n;
    logic [N_PHASE-1:0] low_n;
    logic [SYNC_W:0] hi_len;

    // ==========================================
    // Bus slave
    assign accept = hsel && hready && htrans[1] && ce;
    // Reads take one wait state so that a write just
    // before them is already in the registers
    assign hreadyout = ce && (state != BUS_READ);
    assign hresp = 1'b0;

    // Address phase capture and transfer state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= BUS_IDLE;
            addr_q <= 8'h00;
            addr_ok_q <= 1'b0;
        end else if (ce) begin
            if (state == BUS_READ) begin
                state <= BUS_IDLE;
            end else if (accept) begin
                state <= hwrite ? BUS_WRITE : BUS_READ;
                addr_q <= haddr[7:0];
                addr_ok_q <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
            end else begin
                state <= BUS_IDLE;
            end
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rd_mux = 32'h00000000;
        if (addr_ok_q) begin
            unique case (addr_q)
                ADDR_MODE: rd_mux[MODE_DOUBLE_BIT] = mode_double;
                ADDR_STATUS: rd_mux[STATUS_HALF_BIT] = half;
                ADDR_HALF_PERIOD: rd_mux[CNT_W-1:0] = half_period_count;
                ADDR_DEAD: rd_mux[DEAD_W-1:0] = dead_time_count;
                ADDR_MIN_PULSE: rd_mux[MINP_W-1:0] = min_pulse_count;
                ADDR_SYNC_WIDTH: rd_mux[SYNC_W-1:0] = sync_width_count;
                ADDR_DUTY_A: rd_mux[CNT_W-1:0] = duty_reg[0];
                ADDR_DUTY_B: rd_mux[CNT_W-1:0] = duty_reg[1];
                ADDR_DUTY_C: rd_mux[CNT_W-1:0] = duty_reg[2];
                ADDR_STEER: rd_mux[STEER_W-1:0] = output_steer_enable;
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // Read data is registered during the wait state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h00000000;
        end else if (ce && state == BUS_READ) begin
            hrdata <= rd_mux;
        end
    end

    // Software registers, written in the data phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_double <= 1'b0;
            half_period_count <= HALF_PERIOD_RESET;
            dead_time_count <= DEAD_RESET;
            min_pulse_count <= MIN_PULSE_RESET;
            sync_width_count <= SYNC_WIDTH_RESET;
            duty_reg[0] <= DUTY_RESET;
            duty_reg[1] <= DUTY_RESET;
            duty_reg[2] <= DUTY_RESET;
            output_steer_enable <= STEER_RESET;
        end else if (ce && state == BUS_WRITE && addr_ok_q) begin
            unique case (addr_q)
                ADDR_MODE: mode_double <= hwdata[MODE_DOUBLE_BIT];
                ADDR_HALF_PERIOD: half_period_count <= hwdata[CNT_W-1:0];
                ADDR_DEAD: dead_time_count <= hwdata[DEAD_W-1:0];
                ADDR_MIN_PULSE: min_pulse_count <= hwdata[MINP_W-1:0];
                ADDR_SYNC_WIDTH: sync_width_count <= hwdata[SYNC_W-1:0];
                ADDR_DUTY_A: duty_reg[0] <= hwdata[CNT_W-1:0];
                ADDR_DUTY_B: duty_reg[1] <= hwdata[CNT_W-1:0];
                ADDR_DUTY_C: duty_reg[2] <= hwdata[CNT_W-1:0];
                ADDR_STEER: output_steer_enable <= hwdata[STEER_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // Half-period timebase
    // A zero half period makes every cycle a boundary
    // rather than letting the counter wrap for 65536
    assign at_end = (tm_lat == '0) || (cnt == tm_lat - 16'h0001);
    // Single mode latches at period start only; double also at midpoint
    assign do_latch = at_end && (half || dbl_lat);

    // Counter restarts at every half-period boundary
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
            half <= 1'b1;
        end else if (ce) begin
            if (at_end) begin
                cnt <= '0;
                half <= !half;
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end
    end

    // Shadow copies taken at each sync rising edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tm_lat <= '0;
            dead_lat <= '0;
            min_pulse_active <= '0;
            sync_w_lat <= SYNC_WIDTH_RESET;
            duty_lat[0] <= '0;
            duty_lat[1] <= '0;
            duty_lat[2] <= '0;
            steer_enable_out <= '0;
            dbl_lat <= 1'b0;
        end else if (ce && do_latch) begin
            tm_lat <= half_period_count;
            dead_lat <= dead_time_count;
            min_pulse_active <= min_pulse_count;
            sync_w_lat <= sync_width_count;
            duty_lat[0] <= duty_reg[0];
            duty_lat[1] <= duty_reg[1];
            duty_lat[2] <= duty_reg[2];
            steer_enable_out <= output_steer_enable;
            dbl_lat <= mode_double;
        end
    end

    // ==========================================
    // Sync pulse and interrupt request
    // A new sync restarts the width count, so an over-long
    // width merges into one continuous high level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            period_sync_pulse <= 1'b0;
            sync_rem <= '0;
        end else if (ce) begin
            if (do_latch) begin
                period_sync_pulse <= 1'b1;
                sync_rem <= sync_width_count;
            end else if (sync_rem != '0) begin
                sync_rem <= sync_rem - 8'h01;
            end else begin
                period_sync_pulse <= 1'b0;
            end
        end
    end

    // One-cycle request to the core per sync edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_irq <= 1'b0;
        end else if (ce) begin
            sync_irq <= do_latch;
        end
    end

    // ==========================================
    // Output pairs, one per phase
    for (genvar i = 0; i < N_PHASE; i++) begin : g_phase
        pwm_phase_gen #(
            .CNT_W(CNT_W),
            .DEAD_W(DEAD_W)
        ) u_pair (
            .clk(clk),
            .arst_n(arst_n),
            .ce(ce),
            .cnt(cnt),
            .second_half(half),
            .half_period(tm_lat),
            .dead(dead_lat),
            .duty(duty_lat[i]),
            .high_n(high_n[i]),
            .low_n(low_n[i])
        );
    end

    // Low means switch on
    assign phase_a_high_out = high_n[0];
    assign phase_a_low_out = low_n[0];
    assign phase_b_high_out = high_n[1];
    assign phase_b_low_out = low_n[1];
    assign phase_c_high_out = high_n[2];
    assign phase_c_low_out = low_n[2];

    // ==========================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Length of the current sync high level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_len <= '0;
        end else if (ce) begin
            if (do_latch) begin
                hi_len <= 9'h001;
            end else if (period_sync_pulse && sync_rem != '0) begin
                hi_len <= hi_len + 9'h001;
            end
        end
    end

    property p_sync_width;
        $fell(period_sync_pulse) |-> hi_len == {1'b0, sync_w_lat} + 9'h001;
    endproperty
    a_sync_width: assert property (p_sync_width) else $error("sync width wrong");

    property p_irq_on_rise;
        $rose(period_sync_pulse) |-> sync_irq;
    endproperty
    a_irq_on_rise: assert property (p_irq_on_rise) else $error("sync without irq");

    property p_single_no_mid;
        (sync_irq && !$past(dbl_lat)) |-> !half;
    endproperty
    a_single_no_mid: assert property (p_single_no_mid) else $error("midpoint sync");

    property p_double_mid;
        ($rose(half) && $past(dbl_lat) && $past(ce)) |-> sync_irq;
    endproperty
    a_double_mid: assert property (p_double_mid) else $error("missing midpoint sync");

    property p_first_half;
        ($fell(half) && $past(ce)) |-> sync_irq && cnt == '0;
    endproperty
    a_first_half: assert property (p_first_half) else $error("half bit vs sync");

    property p_steer_latch;
        sync_irq && $past(ce) |-> steer_enable_out == $past(output_steer_enable);
    endproperty
    a_steer_latch: assert property (p_steer_latch) else $error("steer not latched");

    property p_duty_latch;
        sync_irq && $past(ce) |-> duty_lat[0] == $past(duty_reg[0])
            && dead_lat == $past(dead_time_count) && tm_lat == $past(half_period_count);
    endproperty
    a_duty_latch: assert property (p_duty_latch) else $error("settings not latched");

    property p_no_overlap;
        (phase_a_high_out || phase_a_low_out) && (phase_b_high_out || phase_b_low_out)
            && (phase_c_high_out || phase_c_low_out);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both switches on");

    property p_read_wait;
        (accept && !hwrite) |=> !hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait missing");

    c_double_mid: cover property (sync_irq && half && dbl_lat);
    c_full_on: cover property (ce && tm_lat != '0 && !phase_a_high_out [*4]);
    c_dead_gap: cover property ($rose(phase_a_high_out) && dead_lat != '0);
    c_read: cover property (state == BUS_READ ##1 hreadyout);
endmodule
`default_nettype wire

// [verification/gate_drive_model.sv]
// Gate drive side model: per-interval on-times, overlap and sync pulse width
`timescale 1ns/100ps
`default_nettype none
module gate_drive_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Observed pins, gates ordered a, b, c
    input wire logic [2:0] high_n,
    input wire logic [2:0] low_n,
    input wire logic sync,
    input wire logic irq,
    // Measurements of the last closed intervals
    output logic [15:0] hi_on [3],
    output logic [15:0] lo_on [3],
    output logic [15:0] hi_two [3],
    output logic [15:0] lo_two [3],
    output logic [15:0] gap,
    output logic [15:0] width,
    output logic overlap,
    output logic irq_bad
);
    // ==========================================
    // Interval counters
    logic sync_d;
    logic rise;
    logic [15:0] hi_acc [3];
    logic [15:0] lo_acc [3];
    logic [15:0] gap_acc;
    logic [15:0] w_acc;
    assign rise = sync & ~sync_d;
    // A driver turns its switch on at low; intervals run from sync rise to sync rise
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_d <= 1'b0;
            gap_acc <= 16'h0000;
            w_acc <= 16'h0000;
            gap <= 16'h0000;
            width <= 16'h0000;
            overlap <= 1'b0;
            irq_bad <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                hi_acc[i] <= 16'h0000;
                lo_acc[i] <= 16'h0000;
                hi_on[i] <= 16'h0000;
                lo_on[i] <= 16'h0000;
                hi_two[i] <= 16'h0000;
                lo_two[i] <= 16'h0000;
            end
        end else begin
            sync_d <= sync;
            w_acc <= sync ? w_acc + 16'h0001 : 16'h0000;
            if (sync_d && !sync) width <= w_acc;
            if (|(~high_n & ~low_n)) overlap <= 1'b1;
            if (rise && !irq) irq_bad <= 1'b1;
            gap_acc <= rise ? 16'h0001 : gap_acc + 16'h0001;
            if (rise) gap <= gap_acc;
            for (int i = 0; i < 3; i++) begin
                if (rise) begin
                    hi_on[i] <= hi_acc[i];
                    lo_on[i] <= lo_acc[i];
                    hi_two[i] <= hi_acc[i] + hi_on[i];
                    lo_two[i] <= lo_acc[i] + lo_on[i];
                    hi_acc[i] <= {15'h0000, ~high_n[i]};
                    lo_acc[i] <= {15'h0000, ~low_n[i]};
                end else begin
                    hi_acc[i] <= hi_acc[i] + {15'h0000, ~high_n[i]};
                    lo_acc[i] <= lo_acc[i] + {15'h0000, ~low_n[i]};
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verification/three_phase_pwm_timing_unit_tb.sv]
// Self-checking bench for the PWM timing unit and its register file
`timescale 1ns/100ps
`default_nettype none
module three_phase_pwm_timing_unit_tb import pwm_timing_pkg::*;;
    // ==========================================
    // Signals
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic ce = 1'b1;
    logic [6:0] snap;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, sync, irq, overlap, irq_bad;
    logic [31:0] hrdata;
    logic [2:0] high_n, low_n;
    logic [STEER_W-1:0] steer;
    logic [MINP_W-1:0] minp;
    logic [15:0] hi_on [3], lo_on [3], hi_two [3], lo_two [3];
    logic [15:0] gap, width;
    int err_total = 0;
    int checks = 0;
    // 20 MHz clock
    always #25 clk = ~clk;
    // Transfer size held fixed: only word transfers are used
    pwm_timing_unit i_dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .phase_a_high_out(high_n[0]), .phase_a_low_out(low_n[0]),
        .phase_b_high_out(high_n[1]), .phase_b_low_out(low_n[1]),
        .phase_c_high_out(high_n[2]), .phase_c_low_out(low_n[2]),
        .period_sync_pulse(sync), .sync_irq(irq), .steer_enable_out(steer),
        .min_pulse_active(minp));
    gate_drive_model i_gate (
        .clk(clk), .arst_n(arst_n), .high_n(high_n), .low_n(low_n), .sync(sync),
        .irq(irq), .hi_on(hi_on), .lo_on(lo_on), .hi_two(hi_two), .lo_two(lo_two),
        .gap(gap), .width(width), .overlap(overlap), .irq_bad(irq_bad));
    // ==========================================
    // Tasks
    task automatic results;
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for hready high at an edge; a hang ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            err_total++;
            $display("BAD %0t bus hang", $time);
            results();
        end
    endtask
    // One single transfer: address phase, then data phase, each held until hready
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m = 32'hffff_ffff);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        cmp(q & m, e);
        cmp({31'h0, hresp}, 32'h0);
    endtask
    // Counts sync interrupts; the bound is far above the longest period used
    task automatic wait_sync(input int n);
        int t;
        t = 0;
        while (n > 0 && t < 2000) begin
            @(posedge clk);
            t++;
            if (irq === 1'b1) n--;
        end
        if (n > 0) begin
            err_total++;
            $display("BAD %0t no sync", $time);
            results();
        end
    endtask
    function automatic int clip(input int v, input int tm);
        return v < 0 ? 0 : (v > tm ? tm : v);
    endfunction
    // Program counts, let several syncs pass so old settings drain, then measure
    task automatic run_case(input int tm, input int dt, input int d [3], input bit dbl);
        int h, l;
        wr(ADDR_MODE, 32'(dbl) << MODE_DOUBLE_BIT);
        wr(ADDR_HALF_PERIOD, 32'(tm));
        wr(ADDR_DEAD, 32'(dt));
        wr(ADDR_DUTY_A, 32'(d[0]));
        wr(ADDR_DUTY_B, 32'(d[1]));
        wr(ADDR_DUTY_C, 32'(d[2]));
        wait_sync(5);
        repeat (2) @(posedge clk);
        cmp({16'h0, gap}, 32'(dbl ? tm : 2 * tm));
        for (int i = 0; i < 3; i++) begin
            h = clip(d[i] - dt, tm);
            l = clip(tm - d[i] - dt, tm);
            cmp({16'h0, dbl ? hi_two[i] : hi_on[i]}, 32'(2 * h));
            cmp({16'h0, dbl ? lo_two[i] : lo_on[i]}, 32'(2 * l));
        end
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd_chk(ADDR_MODE, 32'h0);
        rd_chk(ADDR_SYNC_WIDTH, 32'h27);
        wr(ADDR_DEAD, 32'hffff_ffff);
        rd_chk(ADDR_DEAD, 32'h3ff);
        wr(ADDR_DUTY_B, 32'hffff_ffff);
        rd_chk(ADDR_DUTY_B, 32'hffff);
        wr(ADDR_MODE, 32'hffff_ffff);
        rd_chk(ADDR_MODE, 32'h40, 32'h40);
        wr(8'h28, 32'h1234);
        rd_chk(8'h28, 32'h0);
        run_case(50, 0, '{25, 10, 50}, 1'b0);
        cmp({16'h0, width}, 32'd40);
        // Half flag: just after a period start, then one half period later
        wait_sync(1);
        rd_chk(ADDR_STATUS, 32'h0, 32'h8);
        repeat (50) @(posedge clk);
        rd_chk(ADDR_STATUS, 32'h8, 32'h8);
        // Settings written mid-period stay out until the next sync
        wait_sync(1);
        wr(ADDR_STEER, 32'h1a5);
        wr(ADDR_MIN_PULSE, 32'h3ff);
        cmp({23'h0, steer}, 32'h0);
        cmp({22'h0, minp}, 32'h0);
        wait_sync(1);
        @(posedge clk);
        cmp({23'h0, steer}, 32'h1a5);
        cmp({22'h0, minp}, 32'h3ff);
        // Clock enable low: bus stalls and every output holds; the snapshot
        // is taken one edge late because the edge that drops ce still updates
        ce <= 1'b0;
        @(posedge clk);
        snap = {high_n, low_n, sync};
        repeat (10) @(posedge clk);
        cmp({31'h0, hreadyout}, 32'h0);
        cmp({25'h0, high_n, low_n, sync}, {25'h0, snap});
        ce <= 1'b1;
        wr(ADDR_SYNC_WIDTH, 32'h0);
        run_case(50, 3, '{20, 3, 60}, 1'b0);
        cmp({16'h0, width}, 32'd1);
        wr(ADDR_SYNC_WIDTH, 32'h5);
        run_case(50, 5, '{0, 49, 26}, 1'b0);
        cmp({16'h0, width}, 32'd6);
        run_case(40, 2, '{30, 12, 40}, 1'b1);
        cmp({31'h0, overlap}, 32'h0);
        cmp({31'h0, irq_bad}, 32'h0);
        results();
    end
endmodule
`default_nettype wire
